// ### core/pst_pkg.sv
// Constants and carrier types for the PLL, lane and trigger config bank
`default_nettype none
package pst_pkg;
    localparam logic [7:0] OFF_OSCILLATOR_BIAS_LEVEL  = 8'h3f;
    localparam logic [7:0] OFF_LANE_PE   = 8'h48;
    localparam logic [7:0] OFF_TRIG_CTRL = 8'h57;
    localparam logic [7:0] OFF_PLL_OVR   = 8'h58;

    localparam logic [7:0] RST_OSCILLATOR_BIAS_LEVEL  = 8'h4f;
    localparam logic [7:0] RST_LANE_PE   = 8'h00;
    localparam logic [7:0] RST_TRIG_CTRL = 8'h00;
    localparam logic [7:0] RST_PLL_OVR   = 8'h00;
    localparam logic [7:0] RD_UNMAPPED   = 8'h00;

    localparam int LANE_COUNT   = 8;
    localparam int BIAS_MSB     = 6;
    localparam int PE_MSB       = 3;
    localparam int TRIG_EN_BIT  = 7;
    localparam int TRIG_SEL_MSB = 2;
    localparam int OVR_EN_BIT   = 7;
    localparam int DSEL_MSB     = 5;
    localparam int DSEL_LSB     = 4;
    localparam int CSEL_MSB     = 3;
    localparam int CSEL_LSB     = 2;
    localparam int SE_BIT       = 1;
    localparam int SYN_EN_BIT   = 0;

    // Trigger output mode codes
    localparam logic [2:0] TRIG_UI16  = 3'h0;
    localparam logic [2:0] TRIG_UI32  = 3'h1;
    localparam logic [2:0] TRIG_UI64  = 3'h2;
    localparam logic [2:0] TRIG_TSTMP = 3'h3;

    // Divided reference select codes
    localparam logic [1:0] DREF_OFF  = 2'h0;
    localparam logic [1:0] DREF_DIV1 = 2'h1;
    localparam logic [1:0] DREF_DIV2 = 2'h2;
    localparam logic [1:0] DREF_DIV4 = 2'h3;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pst_reg_req_t;

    typedef struct packed {
        logic       synth_enable;
        logic       single_ended_ref;
        logic [1:0] c_select;
        logic [1:0] d_select;
    } pst_pll_cfg_t;
endpackage
`default_nettype wire

// ### core/pst_config_regs.sv
// Config register bank with trigger, lane and PLL control outputs
`timescale 1ns/1ps
`default_nettype none
module pst_config_regs (
    input  wire logic                  i_clk,
    input  wire logic                  i_rst,
    input  wire logic                  i_ce,
    input  wire pst_pkg::pst_reg_req_t i_req,
    output var  logic [7:0]            o_rd_data,
    output var  logic                  o_rd_valid,
    output var  logic [6:0]            o_oscillator_bias_level,
    output var  logic [31:0]           o_lane_preemphasis_level,
    output var  logic                  o_trig_out_enable,
    output var  logic [2:0]            o_trig_out_select,
    input  wire logic [2:0]            i_ser_div_taps,
    input  wire logic                  i_ser_reinit,
    input  wire logic                  i_timestamp_input,
    output var  logic                  o_receiver_ref_clock_out,
    input  wire pst_pkg::pst_pll_cfg_t i_pin_cfg,
    input  wire logic                  i_pll_ref_level,
    output var  pst_pkg::pst_pll_cfg_t o_pll_cfg,
    output var  logic                  o_divided_ref_output_c,
    output var  logic                  o_divided_ref_output_d
);
    logic [7:0] vco_q, vco_d;
    logic [7:0] pe_q, pe_d;
    logic [7:0] trig_q, trig_d;
    logic [7:0] ovr_q, ovr_d;
    logic [7:0] rdat_q, rdat_d;
    logic       rval_q, rval_d;

    // Register writes and read answer
    always_comb
    begin
        vco_d  = vco_q;
        pe_d   = pe_q;
        trig_d = trig_q;
        ovr_d  = ovr_q;
        rval_d = i_req.rd;
        rdat_d = pst_pkg::RD_UNMAPPED;
        if (i_req.wr)
        begin
            case (i_req.addr)
                pst_pkg::OFF_OSCILLATOR_BIAS_LEVEL:  vco_d  = i_req.wdata;
                pst_pkg::OFF_LANE_PE:   pe_d   = i_req.wdata;
                pst_pkg::OFF_TRIG_CTRL: trig_d = i_req.wdata;
                pst_pkg::OFF_PLL_OVR:   ovr_d  = i_req.wdata;
                default:                vco_d  = vco_q;
            endcase
        end
        if (i_req.rd)
        begin
            case (i_req.addr)
                pst_pkg::OFF_OSCILLATOR_BIAS_LEVEL:  rdat_d = vco_q;
                pst_pkg::OFF_LANE_PE:   rdat_d = pe_q;
                pst_pkg::OFF_TRIG_CTRL: rdat_d = trig_q;
                pst_pkg::OFF_PLL_OVR:   rdat_d = ovr_q;
                default:                rdat_d = pst_pkg::RD_UNMAPPED;
            endcase
        end
    end

    // Reserved bits are kept as written so reads echo them back
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            vco_q  <= pst_pkg::RST_OSCILLATOR_BIAS_LEVEL;
            pe_q   <= pst_pkg::RST_LANE_PE;
            trig_q <= pst_pkg::RST_TRIG_CTRL;
            ovr_q  <= pst_pkg::RST_PLL_OVR;
            rdat_q <= pst_pkg::RD_UNMAPPED;
            rval_q <= 1'b0;
        end
        else if (i_ce)
        begin
            vco_q  <= vco_d;
            pe_q   <= pe_d;
            trig_q <= trig_d;
            ovr_q  <= ovr_d;
            rdat_q <= rdat_d;
            rval_q <= rval_d;
        end
    end

    // Field outputs, one cycle behind the registers
    logic [6:0]  bias_q;
    logic [31:0] lanes_q, lanes_d;
    logic        ten_q;
    logic [2:0]  tsel_q;

    // one field fans to every lane
    genvar gl;
    generate
        for (gl = 0; gl < pst_pkg::LANE_COUNT; gl++)
        begin : g_lane
            assign lanes_d[gl*4 +: 4] = pe_q[pst_pkg::PE_MSB:0];
        end
    endgenerate

    // Trigger output mux
    logic trig_out_q, trig_out_d;
    logic [2:0] sel;
    always_comb
    begin
        sel        = trig_q[pst_pkg::TRIG_SEL_MSB:0];
        trig_out_d = 1'b0;
        case (sel)
            pst_pkg::TRIG_UI16:  trig_out_d = i_ser_div_taps[0];
            pst_pkg::TRIG_UI32:  trig_out_d = i_ser_div_taps[1];
            pst_pkg::TRIG_UI64:  trig_out_d = i_ser_div_taps[2];
            pst_pkg::TRIG_TSTMP: trig_out_d = i_timestamp_input;
            default:             trig_out_d = 1'b0;
        endcase
        if (sel <= pst_pkg::TRIG_UI64 && i_ser_reinit)
        begin
            trig_out_d = 1'b0;
        end
        if (!trig_q[pst_pkg::TRIG_EN_BIT])
        begin
            trig_out_d = 1'b0;
        end
    end

    // PLL override selection and divided reference
    pst_pkg::pst_pll_cfg_t cfg_q, cfg_d;
    logic [1:0] rcnt_q, rcnt_d;
    logic       rprev_q;
    logic       dc_q, dc_d, dd_q, dd_d;

    function automatic logic dref_tap(input logic [1:0] s,
                                      input logic       r,
                                      input logic [1:0] c);
        begin
            case (s)
                pst_pkg::DREF_DIV1: dref_tap = r;
                pst_pkg::DREF_DIV2: dref_tap = c[0];
                pst_pkg::DREF_DIV4: dref_tap = c[1];
                default:            dref_tap = 1'b0;
            endcase
        end
    endfunction

    always_comb
    begin
        if (ovr_q[pst_pkg::OVR_EN_BIT])
        begin
            cfg_d.synth_enable     = ovr_q[pst_pkg::SYN_EN_BIT];
            cfg_d.single_ended_ref = ovr_q[pst_pkg::SE_BIT];
            cfg_d.c_select = ovr_q[pst_pkg::CSEL_MSB:pst_pkg::CSEL_LSB];
            cfg_d.d_select = ovr_q[pst_pkg::DSEL_MSB:pst_pkg::DSEL_LSB];
        end
        else
        begin
            cfg_d = i_pin_cfg;
        end
        if (cfg_d.c_select == pst_pkg::DREF_OFF)
        begin
            cfg_d.d_select = pst_pkg::DREF_OFF;
        end
        // Count ref rising edges for divide by 2 and 4
        rcnt_d = rcnt_q;
        if (i_pll_ref_level && !rprev_q)
        begin
            rcnt_d = rcnt_q + 2'h1;
        end
        // No ref output while the synthesiser is off
        dc_d = cfg_q.synth_enable
               && dref_tap(cfg_q.c_select, i_pll_ref_level, rcnt_q);
        dd_d = cfg_q.synth_enable
               && dref_tap(cfg_q.d_select, i_pll_ref_level, rcnt_q);
    end

    // Output flops; everything freezes with the clock enable
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            bias_q     <= pst_pkg::RST_OSCILLATOR_BIAS_LEVEL[6:0];
            lanes_q    <= '0;
            ten_q      <= 1'b0;
            tsel_q     <= pst_pkg::TRIG_UI16;
            trig_out_q <= 1'b0;
            cfg_q      <= '0;
            rcnt_q     <= 2'h0;
            rprev_q    <= 1'b0;
            dc_q       <= 1'b0;
            dd_q       <= 1'b0;
        end
        else if (i_ce)
        begin
            bias_q     <= vco_q[pst_pkg::BIAS_MSB:0];
            lanes_q    <= lanes_d;
            ten_q      <= trig_q[pst_pkg::TRIG_EN_BIT];
            tsel_q     <= trig_q[pst_pkg::TRIG_SEL_MSB:0];
            trig_out_q <= trig_out_d;
            cfg_q      <= cfg_d;
            rcnt_q     <= rcnt_d;
            rprev_q    <= i_pll_ref_level;
            dc_q       <= dc_d;
            dd_q       <= dd_d;
        end
    end

    assign o_rd_data                = rdat_q;
    assign o_rd_valid               = rval_q;
    assign o_oscillator_bias_level  = bias_q;
    assign o_lane_preemphasis_level = lanes_q;
    assign o_trig_out_enable        = ten_q;
    assign o_trig_out_select        = tsel_q;
    assign o_receiver_ref_clock_out = trig_out_q;
    assign o_pll_cfg                = cfg_q;
    assign o_divided_ref_output_c   = dc_q;
    assign o_divided_ref_output_d   = dd_q;

    a_bias_write: assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce && i_req.wr && i_req.addr == pst_pkg::OFF_OSCILLATOR_BIAS_LEVEL
        |=> vco_q == $past(i_req.wdata))
        else $error("bias register missed write");
    a_read_back: assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce && i_req.rd && !i_req.wr && i_req.addr == pst_pkg::OFF_PLL_OVR
        |=> o_rd_valid && o_rd_data == ovr_q)
        else $error("read data differs from stored value");
    a_lanes_equal: assert property (@(posedge i_clk) disable iff (i_rst)
        o_lane_preemphasis_level == {8{o_lane_preemphasis_level[3:0]}})
        else $error("lanes differ in pre-emphasis");
    a_trig_off: assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce && !trig_q[pst_pkg::TRIG_EN_BIT] |=> !o_receiver_ref_clock_out)
        else $error("trigger output active while disabled");
    a_trig_stamp: assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce && trig_q == 8'h83 |=> o_receiver_ref_clock_out
        == $past(i_timestamp_input))
        else $error("timestamp mode not followed");
    a_reinit_drop: assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce && i_ser_reinit && trig_q[2:0] <= 3'h2 |=> !o_receiver_ref_clock_out)
        else $error("trigger clock survived reinit");
    a_ovr_pins: assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce && !ovr_q[7] && i_pin_cfg.c_select != 2'h0
        |=> o_pll_cfg == $past(i_pin_cfg))
        else $error("pin config not passed through");
    a_d_needs_c: assert property (@(posedge i_clk) disable iff (i_rst)
        o_divided_ref_output_d && $past(i_ce)
        |-> $past(o_pll_cfg.c_select) != 2'h0)
        else $error("D clock without C clock");
    a_ovr_reset: assert property (@(posedge i_clk)
        i_rst |=> ovr_q == 8'h00 && vco_q == 8'h4f)
        else $error("reset values wrong");
endmodule
`default_nettype wire

// ### bench/tb.sv
// Self-checking bench for the PLL, lane and trigger config bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
    $display("mismatch t=%0t got %h exp %h", $time, (g), (e)); end end
module tb;
    logic                  i_clk = 1'b0;
    logic                  i_rst = 1'b1;
    logic                  i_ce = 1'b1;
    pst_pkg::pst_reg_req_t i_req = '0;
    logic [2:0]            i_ser_div_taps = 3'h0;
    logic                  i_ser_reinit = 1'b0;
    logic                  i_timestamp_input = 1'b0;
    pst_pkg::pst_pll_cfg_t i_pin_cfg = '0;
    logic                  i_pll_ref_level = 1'b0;
    logic [7:0]            o_rd_data;
    logic                  o_rd_valid;
    logic [6:0]            o_bias;
    logic [31:0]           o_lane;
    logic                  o_ten;
    logic [2:0]            o_tsel;
    logic                  o_rx;
    pst_pkg::pst_pll_cfg_t o_pll_cfg;
    logic                  o_dc;
    logic                  o_dd;
    int                    err_total = 0;
    int                    cmp_count = 0;
    // Rows of {address, write data, expected read back}
    // bias left at 0x4a
    localparam logic [23:0] ROWS [6] = '{24'h3f_4f4f, 24'h3f_4a4a,
        24'h48_0505, 24'h58_b5b5, 24'h48_0f0f, 24'h10_ff00};

    pst_config_regs u_pst_config_regs (.i_clk(i_clk), .i_rst(i_rst),
        .i_ce(i_ce), .i_req(i_req), .o_rd_data(o_rd_data),
        .o_rd_valid(o_rd_valid), .o_oscillator_bias_level(o_bias),
        .o_lane_preemphasis_level(o_lane), .o_trig_out_enable(o_ten),
        .o_trig_out_select(o_tsel), .i_ser_div_taps(i_ser_div_taps),
        .i_ser_reinit(i_ser_reinit), .i_timestamp_input(i_timestamp_input),
        .o_receiver_ref_clock_out(o_rx), .i_pin_cfg(i_pin_cfg),
        .i_pll_ref_level(i_pll_ref_level), .o_pll_cfg(o_pll_cfg),
        .o_divided_ref_output_c(o_dc), .o_divided_ref_output_d(o_dd));

    // 200 MHz clock
    always #2.5 i_clk = ~i_clk;

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge i_clk);
        i_req <= '0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_clk);
        i_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge i_clk);
        i_req <= '0;
        #1;
        `CHK(o_rd_valid, 1'b1)
        `CHK(o_rd_data, e)
    endtask

    // Field outputs trail the register by a cycle, so wait past both
    task automatic settle;
        repeat (3) @(posedge i_clk);
        #1;
    endtask

    task automatic rst_chk(input int n);
        @(posedge i_clk);
        i_rst <= 1'b1;
        repeat (n) @(posedge i_clk);
        i_rst <= 1'b0;
        rd_chk(pst_pkg::OFF_OSCILLATOR_BIAS_LEVEL, pst_pkg::RST_OSCILLATOR_BIAS_LEVEL);
        rd_chk(pst_pkg::OFF_LANE_PE, pst_pkg::RST_LANE_PE);
        rd_chk(pst_pkg::OFF_TRIG_CTRL, pst_pkg::RST_TRIG_CTRL);
        rd_chk(pst_pkg::OFF_PLL_OVR, pst_pkg::RST_PLL_OVR);
        `CHK(o_bias, 7'h4f)
        `CHK(o_ten, 1'b0)
    endtask

    task automatic trig(input int m, input logic [2:0] tp, input logic ts,
                        input logic ri);
        logic e;
        @(posedge i_clk);
        i_ser_div_taps <= tp;
        i_timestamp_input <= ts;
        i_ser_reinit <= ri;
        settle();
        e = (m < 3) ? (tp[m] & ~ri) : (m == 3) ? ts : 1'b0;
        `CHK(o_ten, 1'b1)
        `CHK(o_tsel, 3'(m))
        `CHK(o_rx, e)
    endtask

    task automatic pll(input logic [7:0] r, input logic [5:0] pins);
        pst_pkg::pst_pll_cfg_t e;
        @(posedge i_clk);
        i_pin_cfg <= pins;
        i_pll_ref_level <= 1'b1;
        wr_reg(pst_pkg::OFF_PLL_OVR, r);
        settle();
        e = r[7] ? {r[0], r[1], r[3:2], r[5:4]} : pins;
        // D output never runs while C is off
        if (e.c_select == pst_pkg::DREF_OFF)
            e.d_select = pst_pkg::DREF_OFF;
        `CHK(o_pll_cfg, e)
        if (e.c_select < 2'h2)
            `CHK(o_dc, e.synth_enable & e.c_select[0])
        repeat (4)
        begin
            @(posedge i_clk);
            #1;
            if (e.d_select == pst_pkg::DREF_OFF)
                `CHK(o_dd, 1'b0)
        end
    endtask

    // Reference toggles every cycle; C and D output rising edges counted over 32 cycles
    task automatic ref_div(input int ec, input int ed);
        int   nc;
        int   nd;
        logic pc;
        logic pd;
        nc = 0;
        nd = 0;
        pc = 1'b0;
        pd = 1'b0;
        for (int k = 0; k < 40; k++)
        begin
            @(posedge i_clk);
            i_pll_ref_level <= ~i_pll_ref_level;
            #1;
            if (k >= 8)
            begin
                nc += int'(o_dc && !pc);
                nd += int'(o_dd && !pd);
            end
            pc = o_dc;
            pd = o_dd;
        end
        `CHK(nc, ec)
        `CHK(nd, ed)
    endtask

    task automatic test_done;
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Watchdog far beyond the expected run of about 350 cycles
    initial
    begin
        repeat (20000) @(posedge i_clk);
        err_total++;
        test_done();
    end

    initial
    begin
        rst_chk(16);
        foreach (ROWS[i])
        begin
            wr_reg(ROWS[i][23:16], ROWS[i][15:8]);
            rd_chk(ROWS[i][23:16], ROWS[i][7:0]);
            settle();
            if (ROWS[i][23:16] == pst_pkg::OFF_OSCILLATOR_BIAS_LEVEL)
                `CHK(o_bias, ROWS[i][14:8])
            if (ROWS[i][23:16] == pst_pkg::OFF_LANE_PE)
                `CHK(o_lane, {8{ROWS[i][11:8]}})
        end
        // Write and read together: read sees the old value
        @(posedge i_clk);
        i_req <= '{wr: 1'b1, rd: 1'b1, addr: 8'h48, wdata: 8'h03};
        @(posedge i_clk);
        i_req <= '0;
        #1;
        `CHK(o_rd_data, 8'h0f)
        rd_chk(8'h48, 8'h03);
        // No write is taken while the clock enable is low
        @(posedge i_clk);
        i_ce <= 1'b0;
        i_req <= '{wr: 1'b1, rd: 1'b0, addr: 8'h48, wdata: 8'h09};
        repeat (2) @(posedge i_clk);
        i_req <= '0;
        i_ce <= 1'b1;
        rd_chk(8'h48, 8'h03);
        `CHK(o_lane, {8{4'h3}})
        // Mode changed only while disabled, then enabled
        for (int m = 0; m < 8; m++)
        begin
            wr_reg(8'h57, 8'(m));
            wr_reg(8'h57, 8'h80 | 8'(m));
            trig(m, 3'h5, 1'b1, 1'b0);
            trig(m, 3'h2, 1'b0, 1'b0);
            trig(m, 3'h7, 1'b1, 1'b1);
            wr_reg(8'h57, 8'(m));
            settle();
            `CHK(o_rx, 1'b0)
        end
        pll(8'h8f, 6'h00);
        pll(8'hb5, 6'h00);
        pll(8'hb0, 6'h3f);
        pll(8'h00, 6'h32);
        pll(8'h30, 6'h27);
        // C divides by 2, D by 4
        wr_reg(pst_pkg::OFF_PLL_OVR, 8'hb9);
        ref_div(8, 4);
        rst_chk(1);
        test_done();
    end
endmodule
`default_nettype wire
